// >>> common/rsf_pkg.sv
// Constants and types for the result and status flag register bank
package rsf_pkg;

    // ------------------------------------------------------------
    // Output register bank word addresses
    // ------------------------------------------------------------
    localparam logic [2:0] RSF_ADDR_STATUS = 3'h0;
    localparam logic [2:0] RSF_ADDR_TEMP   = 3'h1;
    localparam logic [2:0] RSF_ADDR_CH_A   = 3'h2;
    localparam logic [2:0] RSF_ADDR_CH_B   = 3'h3;
    localparam logic [2:0] RSF_ADDR_CH_C   = 3'h4;
    localparam logic [2:0] RSF_ADDR_TREF_L = 3'h5;
    localparam logic [2:0] RSF_ADDR_TREF_H = 3'h6;

    // ------------------------------------------------------------
    // Widths, limits and field positions
    // ------------------------------------------------------------
    localparam int          RSF_RES_W      = 16;
    localparam int          RSF_TREF_W     = 24;
    localparam int          RSF_NUM_CH     = 3;
    localparam logic [15:0] RSF_RES_MAX    = 16'hFFFF;
    localparam logic [23:0] RSF_TREF_MAX   = 24'hFFFFFF;
    localparam logic [3:0]  RSF_SAT_SEL_MIN = 4'h7;
    localparam logic [7:0]  RSF_ZERO_BYTE  = 8'h00;
    localparam int          RSF_FLG_TREF   = 2;
    localparam int          RSF_FLG_SAT    = 1;
    localparam int          RSF_FLG_OVD    = 0;
    localparam int          RSF_ST_LOST    = 4;
    localparam int          RSF_ST_FRESH   = 3;

    typedef enum logic
    {
        RSF_RD_IDLE = 1'b0,
        RSF_RD_HOLD = 1'b1
    } rsf_rd_state_t;

endpackage : rsf_pkg

// >>> rtl/rsf_result_status_flags.sv
// Result buffering, status flags and byte readout of the output bank
`timescale 1ns/100ps
`default_nettype none

module rsf_result_status_flags
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Mode and control from the configuration logic
    input  wire logic        i_sw_reset,
    input  wire logic        i_meas_state,
    input  wire logic        i_sync_edge_mode,
    input  wire logic        i_time_ref_enable,
    input  wire logic [3:0]  i_conv_time_sel,
    input  wire logic [7:0]  i_osr_byte,
    input  wire logic        i_standby_live,
    input  wire logic        i_powerdown_live,
    // Measurement sequencer events
    input  wire logic        i_meas_start,
    input  wire logic        i_meas_end,
    input  wire logic [2:0]  i_chan_inc,
    input  wire logic [2:0]  i_chan_overdrive,
    // Serial interface engine
    input  wire logic        i_rd_start,
    input  wire logic [2:0]  i_rd_addr,
    input  wire logic        i_byte_req,
    input  wire logic        i_i2c_stop,
    output logic      [7:0]  o_byte_data,
    output logic             o_byte_valid,
    // Status pin
    output logic             o_ready
);
    import rsf_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0]   cnt_reg [RSF_NUM_CH];
    logic [15:0]   cnt_next [RSF_NUM_CH];
    logic [15:0]   buf_reg [RSF_NUM_CH];
    logic [15:0]   buf_next [RSF_NUM_CH];
    logic [15:0]   res_reg [RSF_NUM_CH];
    logic [15:0]   res_next [RSF_NUM_CH];
    logic [23:0]   tref_reg, tref_next;
    logic [23:0]   buf_tref_reg, buf_tref_next;
    logic [23:0]   res_tref_reg, res_tref_next;
    logic [2:0]    run_flg_reg, run_flg_next;
    logic [2:0]    buf_flg_reg, buf_flg_next;
    logic [2:0]    res_flg_reg, res_flg_next;
    logic          fresh_reg, fresh_next;
    logic          lost_reg, lost_next;
    logic          active_reg, active_next;
    rsf_rd_state_t rd_state_reg, rd_state_next;
    logic [2:0]    addr_reg, addr_next;
    logic          sel_reg, sel_next;
    logic [7:0]    data_reg, data_next;
    logic          valid_reg, valid_next;

    logic          bank_clear;
    logic [7:0]    status_byte;
    logic [15:0]   word;
    logic          is_result;

    assign bank_clear = i_sw_reset | ~i_meas_state;
    // Bit 2 live activity, bits 1:0 live power controls
    assign status_byte = {res_flg_reg, lost_reg, fresh_reg, active_reg,
                          i_standby_live, i_powerdown_live};
    assign is_result = (addr_reg >= RSF_ADDR_CH_A)
                    && (addr_reg <= RSF_ADDR_CH_C);

    // ------------------------------------------------------------
    // Word selection for readout
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (addr_reg)
            RSF_ADDR_STATUS: word = {status_byte, i_osr_byte};
            RSF_ADDR_CH_A:   word = res_reg[0];
            RSF_ADDR_CH_B:   word = res_reg[1];
            RSF_ADDR_CH_C:   word = res_reg[2];
            RSF_ADDR_TREF_L: word = res_tref_reg[15:0];
            RSF_ADDR_TREF_H: word = {RSF_ZERO_BYTE, res_tref_reg[23:16]};
            default:         word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        cnt_next      = cnt_reg;
        buf_next      = buf_reg;
        res_next      = res_reg;
        tref_next     = tref_reg;
        buf_tref_next = buf_tref_reg;
        res_tref_next = res_tref_reg;
        run_flg_next  = run_flg_reg;
        buf_flg_next  = buf_flg_reg;
        res_flg_next  = res_flg_reg;
        fresh_next    = fresh_reg;
        lost_next     = lost_reg;
        active_next   = active_reg;
        rd_state_next = rd_state_reg;
        addr_next     = addr_reg;
        sel_next      = sel_reg;
        data_next     = data_reg;
        valid_next    = 1'b0;

        // Measurement counting
        if (i_meas_start)
        begin
            for (int i = 0; i < RSF_NUM_CH; i++)
                cnt_next[i] = 16'h0000;
            tref_next    = 24'h000000;
            run_flg_next = 3'b000;
            active_next  = 1'b1;
        end
        else if (active_reg)
        begin
            for (int i = 0; i < RSF_NUM_CH; i++)
            begin
                if (i_chan_inc[i] && cnt_reg[i] == RSF_RES_MAX)
                begin
                    // Stays at all ones instead of wrapping
                    if (i_conv_time_sel >= RSF_SAT_SEL_MIN)
                        run_flg_next[RSF_FLG_SAT] = 1'b1;
                end
                else if (i_chan_inc[i])
                    cnt_next[i] = cnt_reg[i] + 16'h0001;
            end
            if (|i_chan_overdrive)
                run_flg_next[RSF_FLG_OVD] = 1'b1;
            if (i_time_ref_enable)
            begin
                tref_next = tref_reg + 24'h000001;
                if (tref_reg == RSF_TREF_MAX && i_sync_edge_mode)
                    run_flg_next[RSF_FLG_TREF] = 1'b1;
            end
        end

        // Read-triggered clears; status byte is captured on this edge
        if (i_byte_req && !i_rd_start && sel_reg
            && addr_reg == RSF_ADDR_STATUS)
        begin
            fresh_next = 1'b0;
            lost_next  = 1'b0;
        end
        if (i_byte_req && !i_rd_start && is_result)
            fresh_next = 1'b0;

        // End of measurement: flags travel with their results
        if (i_meas_end && active_reg)
        begin
            buf_next      = cnt_next;
            buf_tref_next = tref_next;
            buf_flg_next  = run_flg_next;
            if (fresh_reg)
                lost_next = 1'b1;
            fresh_next  = 1'b1;
            active_next = 1'b0;
        end

        // Readout
        if (i_rd_start)
        begin
            addr_next = i_rd_addr;
            sel_next  = 1'b0;
            if (rd_state_reg == RSF_RD_IDLE)
            begin
                res_next      = buf_reg;
                res_tref_next = buf_tref_reg;
                res_flg_next  = buf_flg_reg;
                rd_state_next = RSF_RD_HOLD;
            end
        end
        else if (i_byte_req)
        begin
            data_next  = sel_reg ? word[15:8] : word[7:0];
            valid_next = 1'b1;
            sel_next   = ~sel_reg;
            if (sel_reg)
                addr_next = addr_reg + 3'h1;
        end
        if (i_i2c_stop)
            rd_state_next = RSF_RD_IDLE;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < RSF_NUM_CH; i++)
            begin
                cnt_reg[i] <= 16'h0000;
                buf_reg[i] <= 16'h0000;
                res_reg[i] <= 16'h0000;
            end
            tref_reg     <= 24'h000000;
            buf_tref_reg <= 24'h000000;
            res_tref_reg <= 24'h000000;
            run_flg_reg  <= 3'b000;
            buf_flg_reg  <= 3'b000;
            res_flg_reg  <= 3'b000;
            fresh_reg    <= 1'b0;
            lost_reg     <= 1'b0;
            active_reg   <= 1'b0;
            rd_state_reg <= RSF_RD_IDLE;
            addr_reg     <= 3'h0;
            sel_reg      <= 1'b0;
            data_reg     <= 8'h00;
            valid_reg    <= 1'b0;
        end
        else if (bank_clear)
        begin
            for (int i = 0; i < RSF_NUM_CH; i++)
            begin
                cnt_reg[i] <= 16'h0000;
                buf_reg[i] <= 16'h0000;
                res_reg[i] <= 16'h0000;
            end
            tref_reg     <= 24'h000000;
            buf_tref_reg <= 24'h000000;
            res_tref_reg <= 24'h000000;
            run_flg_reg  <= 3'b000;
            buf_flg_reg  <= 3'b000;
            res_flg_reg  <= 3'b000;
            fresh_reg    <= 1'b0;
            lost_reg     <= 1'b0;
            active_reg   <= 1'b0;
            rd_state_reg <= RSF_RD_IDLE;
            addr_reg     <= 3'h0;
            sel_reg      <= 1'b0;
            data_reg     <= 8'h00;
            valid_reg    <= 1'b0;
        end
        else
        begin
            cnt_reg      <= cnt_next;
            buf_reg      <= buf_next;
            res_reg      <= res_next;
            tref_reg     <= tref_next;
            buf_tref_reg <= buf_tref_next;
            res_tref_reg <= res_tref_next;
            run_flg_reg  <= run_flg_next;
            buf_flg_reg  <= buf_flg_next;
            res_flg_reg  <= res_flg_next;
            fresh_reg    <= fresh_next;
            lost_reg     <= lost_next;
            active_reg   <= active_next;
            rd_state_reg <= rd_state_next;
            addr_reg     <= addr_next;
            sel_reg      <= sel_next;
            data_reg     <= data_next;
            valid_reg    <= valid_next;
        end
    end

    assign o_byte_data  = data_reg;
    assign o_byte_valid = valid_reg;
    assign o_ready      = ~active_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    chk_fresh_on_end: assert property (
        i_meas_end && active_reg && !bank_clear |=> fresh_reg)
        else $error("fresh flag not set at measurement end");
    chk_lost_on_overwrite: assert property (
        i_meas_end && active_reg && fresh_reg && !bank_clear |=> lost_reg)
        else $error("lost flag not set on buffer overwrite");
    chk_ready_low_run: assert property (
        i_meas_start && !bank_clear |=> !o_ready ##0 status_byte[2])
        else $error("ready pin or active bit wrong after start");
    chk_sat_holds_max: assert property (
        active_reg && !i_meas_start && i_chan_inc[0] && !bank_clear
        && cnt_reg[0] == RSF_RES_MAX |=> cnt_reg[0] == RSF_RES_MAX)
        else $error("channel counter wrapped past maximum");
    chk_hold_results: assert property (
        rd_state_reg == RSF_RD_HOLD && !bank_clear
        |=> $stable(res_reg[0]) && $stable(res_flg_reg))
        else $error("results changed during read");
    chk_lost_clear_status: assert property (
        i_byte_req && !i_rd_start && addr_reg == RSF_ADDR_STATUS
        && sel_reg && !i_meas_end |=> !lost_reg)
        else $error("lost flag not cleared by status read");
    chk_fresh_clear_res: assert property (
        i_byte_req && !i_rd_start && is_result && !i_meas_end |=> !fresh_reg)
        else $error("fresh flag not cleared by result read");
    chk_low_byte_first: assert property (
        i_byte_req && !i_rd_start && !bank_clear
        && addr_reg == RSF_ADDR_CH_A && !sel_reg
        |=> o_byte_valid && o_byte_data == $past(res_reg[0][7:0]))
        else $error("low byte not sent first");
    chk_status_second: assert property (
        i_byte_req && !i_rd_start && !bank_clear
        && addr_reg == RSF_ADDR_STATUS && sel_reg
        |=> o_byte_data[RSF_ST_LOST] == $past(lost_reg))
        else $error("status byte not second or cleared too early");
    chk_bank_cleared: assert property (
        bank_clear |=> !fresh_reg && !lost_reg && res_flg_reg == 3'b000)
        else $error("bank not cleared");

    cov_lost_data: cover property (i_meas_end && fresh_reg && active_reg);
    cov_read_hold: cover property (
        rd_state_reg == RSF_RD_HOLD ##1 i_meas_end ##[1:20] i_i2c_stop);
    cov_tref_ovf: cover property (res_flg_reg[RSF_FLG_TREF]);

endmodule : rsf_result_status_flags

`default_nettype wire

// >>> testbench/rsf_host_model.sv
// Behavioural host controller that reads words from the output bank
`timescale 1ns/100ps
`default_nettype none
module rsf_host_model
(
    // Clock and byte stream from the bank
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_byte_data,
    input  wire logic       i_byte_valid,
    // Read control towards the bank
    output logic            o_rd_start = 1'b0,
    output logic      [2:0] o_rd_addr = 3'h0,
    output logic            o_byte_req = 1'b0,
    output logic            o_i2c_stop = 1'b0
);
    task automatic send_stop;
        o_i2c_stop = 1'b1;
        @(posedge i_sys_clk) #1 o_i2c_stop = 1'b0;
    endtask : send_stop
    // A strobe that never comes leaves the byte unknown, so it never matches
    task automatic get_byte(input int gap, output logic [7:0] b);
        b = 8'hXX;
        repeat (gap + 1) @(posedge i_sys_clk);
        #1 o_byte_req = 1'b1;
        @(posedge i_sys_clk) #1 o_byte_req = 1'b0;
        for (int i = 0; i < 4 && i_byte_valid !== 1'b1; i++)
            @(posedge i_sys_clk) #1;
        if (i_byte_valid === 1'b1)
            b = i_byte_data;
    endtask : get_byte
    task automatic rd_word(input logic [2:0] a, input int gap,
                           input logic keep, output logic [15:0] w);
        logic [7:0] lo, hi;
        o_rd_start = 1'b1;
        o_rd_addr  = a;
        // Address means nothing after the start pulse, so never leave it stale
        @(posedge i_sys_clk) #1 o_rd_addr = ~a;
        o_rd_start = 1'b0;
        get_byte(gap, lo);
        get_byte(gap, hi);
        w = {hi, lo};
        if (!keep)
            send_stop();
    endtask : rd_word
endmodule : rsf_host_model
`default_nettype wire

// >>> testbench/rsf_result_status_flags_test.sv
// Self-checking bench for the result and status flag bank
`timescale 1ns/100ps
`default_nettype none
module rsf_result_status_flags_test;
    import rsf_pkg::*;
    logic        clk = 1'b0, i_rst = 1'b1, i_sw_reset = 1'b0;
    logic        i_meas_state = 1'b1, i_sync_edge_mode = 1'b0;
    logic        i_time_ref_enable = 1'b1, i_standby_live = 1'b0;
    logic        i_powerdown_live = 1'b0, i_meas_start = 1'b0;
    logic        i_meas_end = 1'b0, i_rd_start, i_byte_req, i_i2c_stop;
    logic        o_byte_valid, o_ready;
    logic [3:0]  i_conv_time_sel = 4'h3;
    logic [7:0]  i_osr_byte = 8'hA5, o_byte_data;
    logic [2:0]  i_chan_inc = 3'h0, i_chan_overdrive = 3'h0, i_rd_addr;
    logic [15:0] w;
    int          errors = 0, checks_done = 0;
    always #4 clk = ~clk;
    rsf_result_status_flags i_rsf_result_status_flags
    (
        .i_sys_clk(clk), .i_rst, .i_sw_reset, .i_meas_state,
        .i_sync_edge_mode, .i_time_ref_enable, .i_conv_time_sel, .i_osr_byte,
        .i_standby_live, .i_powerdown_live, .i_meas_start, .i_meas_end,
        .i_chan_inc, .i_chan_overdrive, .i_rd_start, .i_rd_addr, .i_byte_req,
        .i_i2c_stop, .o_byte_data, .o_byte_valid, .o_ready
    );
    rsf_host_model i_rsf_host_model
    (
        .i_sys_clk(clk), .i_byte_data(o_byte_data),
        .i_byte_valid(o_byte_valid), .o_rd_start(i_rd_start),
        .o_rd_addr(i_rd_addr), .o_byte_req(i_byte_req), .o_i2c_stop(i_i2c_stop)
    );
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Flags: time overflow, saturated, overdrive, lost, fresh, active
    function automatic logic [15:0] st(input logic [5:0] f);
        return {f, i_standby_live, i_powerdown_live, i_osr_byte};
    endfunction : st
    task automatic rdc(input logic [2:0] a, input logic [15:0] exp,
                       input logic keep = 1'b0, input int gap = 0);
        i_rsf_host_model.rd_word(a, gap, keep, w);
        chk(w, exp);
    endtask : rdc
    // All three channels count together, n increments each
    task automatic meas(input int n, input logic [2:0] od, input logic fin);
        i_meas_start = 1'b1;
        @(posedge clk) #1 i_meas_start = 1'b0;
        i_chan_overdrive = od;
        @(posedge clk) #1 i_chan_overdrive = 3'h0;
        i_chan_inc = (n > 0) ? 3'h7 : 3'h0;
        repeat (n) @(posedge clk) #1;
        i_chan_inc = 3'h0;
        i_meas_end = fin;
        @(posedge clk) #1 i_meas_end = 1'b0;
        @(posedge clk) #1;
    endtask : meas
    task automatic t_idle;
        chk({6'h00, o_ready, o_byte_valid, o_byte_data}, 16'h0200);
        i_standby_live = 1'b1;
        rdc(RSF_ADDR_STATUS, st(6'h00));
        i_standby_live   = 1'b0;
        i_powerdown_live = 1'b1;
        rdc(RSF_ADDR_STATUS, st(6'h00), 1'b0, 2);
    endtask : t_idle
    task automatic t_fresh;
        meas(261, 3'h0, 1'b1);
        rdc(RSF_ADDR_STATUS, st(6'h02));
        rdc(RSF_ADDR_STATUS, st(6'h00));
        rdc(RSF_ADDR_CH_A, 16'h0105);
        meas(1, 3'h0, 1'b1);
        rdc(RSF_ADDR_CH_B, 16'h0001);
        rdc(RSF_ADDR_STATUS, st(6'h00));
    endtask : t_fresh
    task automatic t_lost;
        meas(1, 3'h0, 1'b1);
        meas(2, 3'h0, 1'b1);
        rdc(RSF_ADDR_CH_C, 16'h0002);
        rdc(RSF_ADDR_STATUS, st(6'h04));
        rdc(RSF_ADDR_STATUS, st(6'h00));
    endtask : t_lost
    task automatic t_hold;
        meas(2, 3'h0, 1'b1);
        rdc(RSF_ADDR_CH_A, 16'h0002, 1'b1, 3);
        meas(7, 3'h0, 1'b0);
        chk({15'h0000, o_ready}, 16'h0000);
        rdc(RSF_ADDR_STATUS, st(6'h01), 1'b1);
        i_meas_end = 1'b1;
        @(posedge clk) #1 i_meas_end = 1'b0;
        rdc(RSF_ADDR_CH_A, 16'h0002, 1'b1, 3);
        i_rsf_host_model.send_stop();
        rdc(RSF_ADDR_CH_A, 16'h0007);
    endtask : t_hold
    task automatic t_sat;
        i_conv_time_sel  = 4'h7;
        i_sync_edge_mode = 1'b1;
        meas(65540, 3'h2, 1'b1);
        rdc(RSF_ADDR_STATUS, st(6'h1A));
        rdc(RSF_ADDR_CH_B, 16'hFFFF);
        meas(4, 3'h0, 1'b1);
        rdc(RSF_ADDR_STATUS, st(6'h02));
        rdc(RSF_ADDR_TREF_H, 16'h0000);
        rdc(RSF_ADDR_TREF_L, 16'h0006);
        i_time_ref_enable = 1'b0;
        meas(4, 3'h0, 1'b1);
        rdc(RSF_ADDR_TREF_L, 16'h0000);
        i_time_ref_enable = 1'b1;
    endtask : t_sat
    task automatic t_clear;
        meas(3, 3'h0, 1'b1);
        i_sw_reset = 1'b1;
        @(posedge clk) #1 i_sw_reset = 1'b0;
        rdc(RSF_ADDR_CH_A, 16'h0000);
        meas(3, 3'h0, 1'b1);
        i_meas_state = 1'b0;
        @(posedge clk) #1 i_meas_state = 1'b1;
        rdc(RSF_ADDR_STATUS, st(6'h00));
        chk({15'h0000, o_ready}, 16'h0001);
    endtask : t_clear
    task automatic close_out;
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (3) @(posedge clk);
        #1 i_rst = 1'b0;
        t_idle();
        t_fresh();
        t_lost();
        t_hold();
        t_sat();
        t_clear();
        close_out();
    end
    // The saturating count dominates the run at about 66k cycles
    initial
    begin
        #720000 errors++;
        close_out();
    end
endmodule : rsf_result_status_flags_test
`default_nettype wire
